// ==== include/dpi_pkg.sv ====
// Purpose: shared constants and types for the dram power-up/initialisation tracker
// Assumes: 10 MHz fabric clock, pins sampled through a two-stage synchroniser
// Notes:   register offsets are byte addresses on a 32-bit axi4-lite slave
package dpi_pkg;

  localparam int unsigned CLK_MHZ        = 10;
  localparam int unsigned INIT_WAIT_US   = 500;
  localparam int unsigned INIT_WAIT_CYC  = INIT_WAIT_US * CLK_MHZ;
  localparam int unsigned DLLK_CYC_DEF   = 512;  // plain default, set per application
  localparam int unsigned ZQINIT_CYC_DEF = 512;  // plain default, set per application
  localparam int unsigned CNT_W          = 16;

  localparam int unsigned ADDR_W    = 15;
  localparam int unsigned BA_W      = 3;
  localparam int unsigned NUM_BANKS = 8;
  localparam int unsigned NUM_MR    = 4;
  localparam int unsigned BEAT_W    = 3;

  // command pins, active-low strobes as on the pins
  typedef struct packed {
    logic              reset_n;
    logic              cke;
    logic              odt;
    logic              cs_n;
    logic              ras_n;
    logic              cas_n;
    logic              we_n;
    logic [BA_W-1:0]   ba;
    logic [ADDR_W-1:0] addr;
  } dpi_pins_s;

  localparam dpi_pins_s PINS_IDLE = '{reset_n: 1'b0, cke: 1'b0, odt: 1'b0, cs_n: 1'b1, ras_n: 1'b1,
                                      cas_n: 1'b1, we_n: 1'b1, ba: 3'h0, addr: 15'h0000};

  // {ras_n, cas_n, we_n} with cs_n low
  localparam logic [2:0] CMD_MRS = 3'h0;
  localparam logic [2:0] CMD_REF = 3'h1;
  localparam logic [2:0] CMD_PRE = 3'h2;
  localparam logic [2:0] CMD_ACT = 3'h3;
  localparam logic [2:0] CMD_WR  = 3'h4;
  localparam logic [2:0] CMD_RD  = 3'h5;
  localparam logic [2:0] CMD_ZQ  = 3'h6;
  localparam logic [2:0] CMD_NOP = 3'h7;

  localparam logic [BA_W-1:0] BA_MR0 = 3'h0;
  localparam logic [BA_W-1:0] BA_MR1 = 3'h1;
  localparam logic [BA_W-1:0] BA_MR2 = 3'h2;
  localparam logic [BA_W-1:0] BA_MR3 = 3'h3;
  localparam logic [2:0]      STEP_ZQ = 3'h4;

  localparam int unsigned A_AP     = 10;
  localparam int unsigned A_BC     = 12;
  localparam int unsigned A_DLL_EN = 0;
  localparam int unsigned A_DLL_RS = 8;
  localparam int unsigned MR0_BT   = 3;
  localparam logic [1:0]  BL_FIX8  = 2'h0;
  localparam logic [1:0]  BL_OTF   = 2'h1;
  localparam logic [1:0]  BL_FIX4  = 2'h2;
  localparam logic [2:0]  PAIRS_BL8 = 3'h4;
  localparam logic [2:0]  PAIRS_BC4 = 3'h2;

  typedef enum logic [5:0] {
    ST_RESET = 6'h01,
    ST_WAIT  = 6'h02,
    ST_CKE   = 6'h04,
    ST_MRS   = 6'h08,
    ST_CAL   = 6'h10,
    ST_READY = 6'h20
  } dpi_state_e;

  localparam logic [31:0] REG_STATUS  = 32'h0000_0000;
  localparam logic [31:0] REG_CONTROL = 32'h0000_0004;
  localparam logic [31:0] REG_ACCESS  = 32'h0000_0008;
  localparam logic [31:0] REG_MR0     = 32'h0000_0010;
  localparam logic [31:0] REG_MR1     = 32'h0000_0014;
  localparam logic [31:0] REG_MR2     = 32'h0000_0018;
  localparam logic [31:0] REG_MR3     = 32'h0000_001c;

  localparam int unsigned CTRL_CLR_ERR  = 0;
  localparam int unsigned CTRL_CHECK_EN = 1;
  localparam logic [1:0]  CTRL_RESET    = 2'h2;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;

endpackage : dpi_pkg

// ==== verilog/dpi_burst_col.sv ====
// Purpose: column offset of one data beat within a burst
// Assumes: beat index 0..7, chopped bursts use beats 0..3 only
// Notes:   pure combinational, one instance per beat of a pair
module dpi_burst_col
  import dpi_pkg::*;
(
  input  wire logic [BEAT_W-1:0] start_in,
  input  wire logic [BEAT_W-1:0] beat_in,
  input  wire logic              interleave_in,
  input  wire logic              chop_in,
  input  wire logic              write_in,
  output logic      [BEAT_W-1:0] col_out
);
  logic [BEAT_W-1:0] start_eff;
  logic [1:0]        low_sum;

  always_comb begin
    // writes ignore the low start bits; full-burst writes ignore the start entirely
    if (write_in) begin
      start_eff = chop_in ? {start_in[2], 2'h0} : 3'h0;
    end else begin
      start_eff = start_in;
    end
    low_sum = start_eff[1:0] + beat_in[1:0];
    if (interleave_in) begin
      col_out = start_eff ^ beat_in;
    end else begin
      col_out = {start_eff[2] ^ beat_in[2], low_sum};
    end
  end
endmodule : dpi_burst_col

// ==== verilog/dpi_top.sv ====
// Purpose: device-side tracker of dram reset, initialisation and burst column order
// Assumes: command pins are asynchronous to clk_in and pass two flip-flops first
// Notes:   mode register contents readable over axi4-lite; sequence errors are sticky
//
// The implementer's own choices: the placing of the registers and the AXI4-Lite interface to the registers.
module dpi_top
  import dpi_pkg::*;
#(
  parameter int unsigned INIT_WAIT  = INIT_WAIT_CYC,
  parameter int unsigned DLLK_WAIT  = DLLK_CYC_DEF,
  parameter int unsigned ZQINIT_WAIT = ZQINIT_CYC_DEF
) (
  input  wire logic              clk_in,
  input  wire logic              resetn_in,
  input  wire dpi_pins_s         pins_in,
  input  wire logic [31:0]       axi_awaddr_in,
  input  wire logic              axi_awvalid_in,
  output logic                   axi_awready_out,
  input  wire logic [31:0]       axi_wdata_in,
  input  wire logic [3:0]        axi_wstrb_in,
  input  wire logic              axi_wvalid_in,
  output logic                   axi_wready_out,
  output logic [1:0]             axi_bresp_out,
  output logic                   axi_bvalid_out,
  input  wire logic              axi_bready_in,
  input  wire logic [31:0]       axi_araddr_in,
  input  wire logic              axi_arvalid_in,
  output logic                   axi_arready_out,
  output logic [31:0]            axi_rdata_out,
  output logic [1:0]             axi_rresp_out,
  output logic                   axi_rvalid_out,
  input  wire logic              axi_rready_in,
  output logic                   ready_out,
  output logic                   odt_en_out,
  output logic                   beat_valid_out,
  output logic                   beat_write_out,
  output logic [BEAT_W-1:0]      beat_even_col_out,
  output logic [BEAT_W-1:0]      beat_odd_col_out
);
  localparam int unsigned CAL_WAIT = (DLLK_WAIT > ZQINIT_WAIT) ? DLLK_WAIT : ZQINIT_WAIT;

  dpi_pins_s sync1_reg, sync2_reg;
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      sync1_reg <= PINS_IDLE;
      sync2_reg <= PINS_IDLE;
    end else begin
      sync1_reg <= pins_in;
      sync2_reg <= sync1_reg;
    end
  end

  // command decode, only while cke is registered high
  logic       cmd_valid, dev_rst;
  logic [2:0] cmd;
  assign dev_rst   = !sync2_reg.reset_n;
  assign cmd_valid = sync2_reg.cke && !sync2_reg.cs_n && !dev_rst;
  assign cmd       = cmd_valid ? {sync2_reg.ras_n, sync2_reg.cas_n, sync2_reg.we_n} : CMD_NOP;

  logic [1:0] ctrl_reg, ctrl_next;
  logic       err_clr;

  // ---------------- initialisation sequence ----------------
  dpi_state_e        state_reg, state_next;
  logic [CNT_W-1:0]  cnt_reg, cnt_next;
  logic [2:0]        step_reg, step_next;
  logic              err_reg, err_next, err_set;
  logic              ready_reg, ready_next, odt_reg, odt_next;
  logic [BA_W-1:0]   exp_ba;

  always_comb begin
    unique case (step_reg)
      3'h0:    exp_ba = BA_MR2;
      3'h1:    exp_ba = BA_MR3;
      3'h2:    exp_ba = BA_MR1;
      default: exp_ba = BA_MR0;
    endcase
  end

  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    step_next  = step_reg;
    err_set    = 1'b0;
    if (dev_rst) begin
      state_next = ST_RESET;
      step_next  = 3'h0;
    end else begin
      unique case (state_reg)
        ST_RESET: begin
          state_next = ST_WAIT;
          cnt_next   = CNT_W'(INIT_WAIT);
        end
        ST_WAIT: begin
          if (sync2_reg.cke) begin
            err_set = 1'b1;
          end
          if (cnt_reg != '0) begin
            cnt_next = cnt_reg - CNT_W'(1);
          end else begin
            state_next = ST_CKE;
          end
        end
        ST_CKE: begin
          if (sync2_reg.cke) begin
            state_next = ST_MRS;
          end
        end
        ST_MRS: begin
          if (!sync2_reg.cke) begin
            err_set = 1'b1;
          end
          if (cmd == CMD_MRS) begin
            if (step_reg == STEP_ZQ || sync2_reg.ba != exp_ba) begin
              err_set = 1'b1;
            end
            if (sync2_reg.ba == BA_MR1 && sync2_reg.addr[A_DLL_EN]) begin
              err_set = 1'b1;
            end
            if (sync2_reg.ba == BA_MR0 && !sync2_reg.addr[A_DLL_RS]) begin
              err_set = 1'b1;
            end
            if (step_reg != STEP_ZQ) begin
              step_next = step_reg + 3'h1;
            end
          end else if (cmd == CMD_ZQ && sync2_reg.addr[A_AP]) begin
            if (step_reg != STEP_ZQ) begin
              err_set = 1'b1;
            end
            state_next = ST_CAL;
            cnt_next   = CNT_W'(CAL_WAIT);
          end else if (cmd != CMD_NOP) begin
            err_set = 1'b1;
          end
        end
        ST_CAL: begin
          if (!sync2_reg.cke) begin
            err_set = 1'b1;
          end
          if (cnt_reg != '0) begin
            cnt_next = cnt_reg - CNT_W'(1);
          end else begin
            state_next = ST_READY;
          end
        end
        ST_READY: begin
          state_next = ST_READY;
        end
        default: state_next = ST_RESET;
      endcase
    end
    // set wins over a software clear
    err_next   = (err_reg && !err_clr) || (err_set && ctrl_reg[CTRL_CHECK_EN]);
    ready_next = (state_next == ST_READY);
    // termination held off until cke registers high
    odt_next   = !(state_next inside {ST_RESET, ST_WAIT, ST_CKE}) && sync2_reg.odt;
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      state_reg <= ST_RESET;
      cnt_reg   <= '0;
      step_reg  <= 3'h0;
      err_reg   <= 1'b0;
      ready_reg <= 1'b0;
      odt_reg   <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      step_reg  <= step_next;
      err_reg   <= err_next;
      ready_reg <= ready_next;
      odt_reg   <= odt_next;
    end
  end

  // ---------------- mode registers ----------------
  logic [ADDR_W-1:0] mr_reg   [NUM_MR];
  logic [ADDR_W-1:0] mr_next  [NUM_MR];
  logic [NUM_MR-1:0] mrw_reg, mrw_next;

  always_comb begin
    mr_next  = mr_reg;
    mrw_next = mrw_reg;
    if (dev_rst) begin
      mrw_next = '0;
    end else if (cmd == CMD_MRS && sync2_reg.ba[2] == 1'b0) begin
      mr_next[sync2_reg.ba[1:0]]  = sync2_reg.addr;
      mrw_next[sync2_reg.ba[1:0]] = 1'b1;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      mr_reg  <= '{default: '0};
      mrw_reg <= '0;
    end else begin
      mr_reg  <= mr_next;
      mrw_reg <= mrw_next;
    end
  end

  // ---------------- banks and bursts ----------------
  logic [ADDR_W-1:0]    row_reg  [NUM_BANKS];
  logic [ADDR_W-1:0]    row_next [NUM_BANKS];
  logic [NUM_BANKS-1:0] open_reg, open_next;
  logic [2:0]           pairs_reg, pairs_next, pair_reg, pair_next;
  logic [BEAT_W-1:0]    start_reg, start_next;
  logic                 il_reg, il_next, chop_reg, chop_next, wr_reg, wr_next;
  logic [20:0]          acc_reg, acc_next;
  logic                 chop_cmd, rw_cmd;
  logic [BEAT_W-1:0]    col_even, col_odd;
  logic                 bv_next;

  assign rw_cmd = (cmd == CMD_RD || cmd == CMD_WR);

  always_comb begin
    unique case (mr_reg[0][1:0])
      BL_OTF:  chop_cmd = !sync2_reg.addr[A_BC];
      BL_FIX4: chop_cmd = 1'b1;
      default: chop_cmd = 1'b0;
    endcase
  end

  always_comb begin
    row_next   = row_reg;
    open_next  = open_reg;
    pairs_next = pairs_reg;
    pair_next  = pair_reg;
    start_next = start_reg;
    il_next    = il_reg;
    chop_next  = chop_reg;
    wr_next    = wr_reg;
    acc_next   = acc_reg;
    bv_next    = (pairs_reg != 3'h0);
    if (pairs_reg != 3'h0) begin
      pairs_next = pairs_reg - 3'h1;
      pair_next  = pair_reg + 3'h1;
    end
    if (dev_rst) begin
      open_next  = '0;
      pairs_next = 3'h0;
    end else if (cmd == CMD_ACT) begin
      row_next[sync2_reg.ba]  = sync2_reg.addr;
      open_next[sync2_reg.ba] = 1'b1;
    end else if (cmd == CMD_PRE) begin
      if (sync2_reg.addr[A_AP]) begin
        open_next = '0;
      end else begin
        open_next[sync2_reg.ba] = 1'b0;
      end
    end else if (rw_cmd && open_reg[sync2_reg.ba] && state_reg == ST_READY) begin
      pairs_next = chop_cmd ? PAIRS_BC4 : PAIRS_BL8;
      pair_next  = 3'h0;
      start_next = sync2_reg.addr[BEAT_W-1:0];
      il_next    = mr_reg[0][MR0_BT];
      chop_next  = chop_cmd;
      wr_next    = (cmd == CMD_WR);
      acc_next   = {wr_next, chop_cmd, sync2_reg.addr[A_AP], sync2_reg.ba, sync2_reg.addr};
      if (sync2_reg.addr[A_AP]) begin
        open_next[sync2_reg.ba] = 1'b0;
      end
    end
    // mode writes fall through: bank and row state is kept
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      row_reg   <= '{default: '0};
      open_reg  <= '0;
      pairs_reg <= 3'h0;
      pair_reg  <= 3'h0;
      start_reg <= '0;
      il_reg    <= 1'b0;
      chop_reg  <= 1'b0;
      wr_reg    <= 1'b0;
      acc_reg   <= '0;
    end else begin
      row_reg   <= row_next;
      open_reg  <= open_next;
      pairs_reg <= pairs_next;
      pair_reg  <= pair_next;
      start_reg <= start_next;
      il_reg    <= il_next;
      chop_reg  <= chop_next;
      wr_reg    <= wr_next;
      acc_reg   <= acc_next;
    end
  end

  // two beats per clock: even and odd beat of the current pair
  dpi_burst_col u_col_even (.start_in(start_reg), .beat_in({pair_reg[1:0], 1'b0}), .interleave_in(il_reg),
                            .chop_in(chop_reg), .write_in(wr_reg), .col_out(col_even));
  dpi_burst_col u_col_odd  (.start_in(start_reg), .beat_in({pair_reg[1:0], 1'b1}), .interleave_in(il_reg),
                            .chop_in(chop_reg), .write_in(wr_reg), .col_out(col_odd));

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      beat_valid_out    <= 1'b0;
      beat_write_out    <= 1'b0;
      beat_even_col_out <= '0;
      beat_odd_col_out  <= '0;
    end else begin
      beat_valid_out    <= bv_next;
      beat_write_out    <= wr_reg;
      beat_even_col_out <= col_even;
      beat_odd_col_out  <= col_odd;
    end
  end

  assign ready_out  = ready_reg;
  assign odt_en_out = odt_reg;

  // ---------------- axi4-lite slave ----------------
  logic        awf_reg, awf_next, wf_reg, wf_next, bv_reg, bvn;
  logic [31:0] awa_reg, awa_next, wd_reg, wd_next, rd_next;
  logic [3:0]  ws_reg, ws_next;
  logic [1:0]  br_next, rr_next;
  logic        rv_next, wdo;
  logic [31:0] status_w;

  assign status_w = {16'h0000, step_reg, mrw_reg, err_reg, odt_reg, ready_reg, state_reg};
  assign wdo      = awf_reg && wf_reg && !bv_reg;
  assign err_clr  = wdo && awa_reg == REG_CONTROL && ws_reg[0] && wd_reg[CTRL_CLR_ERR];

  always_comb begin
    awf_next  = awf_reg || (axi_awvalid_in && !awf_reg);
    wf_next   = wf_reg || (axi_wvalid_in && !wf_reg);
    awa_next  = (axi_awvalid_in && !awf_reg) ? axi_awaddr_in : awa_reg;
    wd_next   = (axi_wvalid_in && !wf_reg) ? axi_wdata_in : wd_reg;
    ws_next   = (axi_wvalid_in && !wf_reg) ? axi_wstrb_in : ws_reg;
    bvn       = bv_reg && !axi_bready_in;
    br_next   = axi_bresp_out;
    ctrl_next = ctrl_reg;
    if (wdo) begin
      awf_next = 1'b0;
      wf_next  = 1'b0;
      bvn      = 1'b1;
      br_next  = (awa_reg inside {REG_STATUS, REG_CONTROL, REG_ACCESS, REG_MR0, REG_MR1, REG_MR2, REG_MR3})
                 ? RESP_OKAY : RESP_SLVERR;
      if (awa_reg == REG_CONTROL && ws_reg[0]) begin
        ctrl_next = {wd_reg[CTRL_CHECK_EN], 1'b0};
      end
    end
    rv_next = axi_rvalid_out && !axi_rready_in;
    rd_next = axi_rdata_out;
    rr_next = axi_rresp_out;
    if (axi_arvalid_in && !axi_rvalid_out) begin
      rv_next = 1'b1;
      rr_next = RESP_OKAY;
      unique case (axi_araddr_in)
        REG_STATUS:  rd_next = status_w;
        REG_CONTROL: rd_next = {30'h0, ctrl_reg};
        REG_ACCESS:  rd_next = {11'h000, acc_reg};
        REG_MR0:     rd_next = {17'h00000, mr_reg[0]};
        REG_MR1:     rd_next = {17'h00000, mr_reg[1]};
        REG_MR2:     rd_next = {17'h00000, mr_reg[2]};
        REG_MR3:     rd_next = {17'h00000, mr_reg[3]};
        default: begin
          rd_next = 32'h0000_0000;
          rr_next = RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      awf_reg <= 1'b0; wf_reg <= 1'b0; bv_reg <= 1'b0;
      awa_reg <= '0; wd_reg <= '0; ws_reg <= '0; ctrl_reg <= CTRL_RESET;
      axi_awready_out <= 1'b0; axi_wready_out <= 1'b0; axi_arready_out <= 1'b0;
      axi_bvalid_out <= 1'b0; axi_bresp_out <= RESP_OKAY;
      axi_rvalid_out <= 1'b0; axi_rresp_out <= RESP_OKAY; axi_rdata_out <= '0;
    end else begin
      awf_reg <= awf_next; wf_reg <= wf_next; bv_reg <= bvn;
      awa_reg <= awa_next; wd_reg <= wd_next; ws_reg <= ws_next; ctrl_reg <= ctrl_next;
      axi_awready_out <= !awf_next; axi_wready_out <= !wf_next; axi_arready_out <= !rv_next;
      axi_bvalid_out <= bvn; axi_bresp_out <= br_next;
      axi_rvalid_out <= rv_next; axi_rresp_out <= rr_next; axi_rdata_out <= rd_next;
    end
  end

  // ---------------- assertions ----------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);

  sequence s_rw_open;
    rw_cmd && open_reg[sync2_reg.ba] && state_reg == ST_READY;
  endsequence
  property p_odt_off;
    state_reg inside {ST_RESET, ST_WAIT, ST_CKE} |-> !odt_en_out;
  endproperty
  a_odt_off: assert property (p_odt_off) else $error("termination on before cke");
  property p_wait_start;
    state_reg == ST_RESET && !dev_rst |=> state_reg == ST_WAIT && cnt_reg == CNT_W'(INIT_WAIT);
  endproperty
  a_wait_start: assert property (p_wait_start) else $error("init wait not loaded");
  property p_order;
    state_reg == ST_MRS && cmd == CMD_MRS && sync2_reg.ba != exp_ba && ctrl_reg[CTRL_CHECK_EN] |=> err_reg;
  endproperty
  a_order: assert property (p_order) else $error("out of order mode write not flagged");
  property p_bl8;
    s_rw_open and !chop_cmd |=> (pairs_reg != 3'h0)[*4] ##1 pairs_reg == 3'h0;
  endproperty
  a_bl8: assert property (p_bl8) else $error("full burst not four clocks");
  property p_bc4;
    s_rw_open and chop_cmd |=> (pairs_reg != 3'h0)[*2] ##1 pairs_reg == 3'h0;
  endproperty
  a_bc4: assert property (p_bc4) else $error("chopped burst not two clocks");
  property p_pair;
    beat_valid_out |-> beat_odd_col_out != beat_even_col_out && beat_even_col_out[2] == beat_odd_col_out[2];
  endproperty
  a_pair: assert property (p_pair) else $error("beat pair malformed");
  property p_act;
    cmd == CMD_ACT |=> open_reg[$past(sync2_reg.ba)] && row_reg[$past(sync2_reg.ba)] == $past(sync2_reg.addr);
  endproperty
  a_act: assert property (p_act) else $error("row not opened");
  property p_ap;
    s_rw_open |=> acc_reg[18] == $past(sync2_reg.addr[A_AP]) && (acc_reg[18] -> !open_reg[acc_reg[17:15]]);
  endproperty
  a_ap: assert property (p_ap) else $error("auto precharge mishandled");
  property p_keep;
    cmd == CMD_MRS |=> open_reg == $past(open_reg);
  endproperty
  a_keep: assert property (p_keep) else $error("mode write disturbed bank state");
  property p_mr_clr;
    dev_rst |=> mrw_reg == '0 && !ready_out;
  endproperty
  a_mr_clr: assert property (p_mr_clr) else $error("mode state kept over reset");
  property p_ready;
    $rose(ready_out) |-> $past(state_reg) == ST_CAL && $past(cnt_reg) == '0;
  endproperty
  a_ready: assert property (p_ready) else $error("ready before calibration wait");

endmodule : dpi_top

// ==== tb/dpi_ctrl_model.sv ====
// Purpose: controller stand-in driving the dram pins
// Assumes: pins change just after clk_in rises
// Notes:   breaks mode order only when asked
module dpi_ctrl_model
  import dpi_pkg::*;
#(
  parameter int unsigned W = 20
) (
  input  wire logic clk_in,
  output dpi_pins_s pins_out
);
  timeunit 1ns;
  timeprecision 1ns;
  initial pins_out = PINS_IDLE;
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_in);
  endtask : cyc
  // released lines flip so a stale value never passes
  task automatic cmd(input logic [2:0] c, input logic [2:0] b, input logic [14:0] a);
    @(posedge clk_in);
    pins_out[21:0] <= {1'h0, c, b, a};
    @(posedge clk_in);
    pins_out[20:0] <= {CMD_NOP, ~b, ~a};
    cyc(4);
  endtask : cmd
  task automatic rst(input int n);
    @(posedge clk_in);
    pins_out.reset_n <= 1'h0;
    pins_out.cke <= 1'h0;
    pins_out.odt <= 1'h1;
    cyc(n);
    pins_out.reset_n <= 1'h1;
  endtask : rst
  // termination pin is free once cke has registered high
  task automatic term(input logic v);
    @(posedge clk_in);
    pins_out.odt <= v;
  endtask : term
  task automatic init(input logic bad);
    cyc(W + 4);
    pins_out.odt <= 1'h0;
    cyc(2);
    pins_out.cke <= 1'h1;
    cyc(5);
    cmd(CMD_MRS, bad ? BA_MR3 : BA_MR2, 15'h0008);
    cmd(CMD_MRS, BA_MR3, 15'h0004);
    cmd(CMD_MRS, BA_MR1, 15'h0040);
    cmd(CMD_MRS, BA_MR0, 15'h0100);
    cmd(CMD_ZQ, 3'h0, 15'h0400);
  endtask : init
endmodule : dpi_ctrl_model

// ==== tb/testbench.sv ====
// Purpose: bench for the dram init tracker
// Assumes: waits shortened through parameters
// Notes:   registers reached over axi4-lite
`define CHK(n, e, s) begin n_tests++; if ((s) !== (e)) begin n_fail++; $display("MISMATCH %s exp %h got %h", n, e, s); end end
module testbench;
  import dpi_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_in, resetn_in, awv, wv, brdy, arv, rrdy;
  logic        bv, rv, awr, wrr, arr, ready_out, odt_en_out, bt_v, bt_w;
  logic [31:0] awa, wd, ara, rdat, d;
  logic [3:0]  ws;
  logic [1:0]  br, rr;
  logic [2:0]  be, bo;
  logic [2:0]  ev [4] = '{3'h1, 3'h3, 3'h5, 3'h7};
  logic [2:0]  od [4] = '{3'h2, 3'h0, 3'h6, 3'h4};
  logic [14:0] mrv [4] = '{15'h0100, 15'h0040, 15'h0008, 15'h0004};
  dpi_pins_s   pins;
  int          n_fail = 0, n_tests = 0, cycles = 0;
  dpi_ctrl_model #(.W(20)) ctrl_u (.clk_in(clk_in), .pins_out(pins));
  dpi_top #(.INIT_WAIT(20), .DLLK_WAIT(8), .ZQINIT_WAIT(8)) dut_u (.clk_in(clk_in), .resetn_in(resetn_in),
    .pins_in(pins), .axi_awaddr_in(awa), .axi_awvalid_in(awv), .axi_awready_out(awr), .axi_wdata_in(wd),
    .axi_wstrb_in(ws), .axi_wvalid_in(wv), .axi_wready_out(wrr), .axi_bresp_out(br), .axi_bvalid_out(bv),
    .axi_bready_in(brdy), .axi_araddr_in(ara), .axi_arvalid_in(arv), .axi_arready_out(arr), .axi_rdata_out(rdat),
    .axi_rresp_out(rr), .axi_rvalid_out(rv), .axi_rready_in(rrdy), .ready_out(ready_out), .odt_en_out(odt_en_out),
    .beat_valid_out(bt_v), .beat_write_out(bt_w), .beat_even_col_out(be), .beat_odd_col_out(bo));
  always #50 clk_in = ~clk_in;
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : complete_run
  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      n_fail++;
      complete_run();
    end
  end
  task automatic rd(input logic [31:0] a);
    @(posedge clk_in);
    {ara, arv, rrdy} <= {a, 2'h3};
    do @(posedge clk_in); while (arr !== 1'h1);
    arv <= 1'h0;
    while (rv !== 1'h1) @(posedge clk_in);
    d = rdat;
    rrdy <= 1'h0;
  endtask : rd
  task automatic wr(input logic [31:0] a, input logic [31:0] v, input logic [3:0] s);
    bit ga = 1'h0, gw = 1'h0;
    @(posedge clk_in);
    {awa, wd, ws, awv, wv, brdy} <= {a, v, s, 3'h7};
    while (!(ga && gw)) begin
      @(posedge clk_in);
      ga |= (awr === 1'h1);
      gw |= (wrr === 1'h1);
      if (ga) awv <= 1'h0;
      if (gw) wv <= 1'h0;
    end
    while (bv !== 1'h1) @(posedge clk_in);
    brdy <= 1'h0;
  endtask : wr
  // read burst, pairs compared against ev/od
  task automatic burst(input logic [2:0] b, input logic [14:0] a, input int n);
    fork
      ctrl_u.cmd(CMD_RD, b, a);
      begin
        for (int i = 0; i < 20 && bt_v !== 1'h1; i++) @(posedge clk_in);
        for (int p = 0; p < n; p++) begin
          `CHK("even col", {ev[p], 1'h0}, {be, bt_w})
          `CHK("odd col", od[p], bo)
          @(posedge clk_in);
        end
        `CHK("burst end", 1'h0, bt_v)
      end
    join
  endtask : burst
  initial begin
    clk_in = 1'h0;
    {resetn_in, awv, wv, brdy, arv, rrdy, ws} <= '0;
    {awa, wd, ara} <= '0;
    repeat (12) @(posedge clk_in);
    resetn_in <= 1'h1;
    rd(REG_CONTROL);
    `CHK("control", 32'h2, d)
    wr(REG_CONTROL, 32'h0, 4'h0);
    `CHK("bresp", RESP_OKAY, br)
    rd(REG_CONTROL);
    `CHK("strobe", 32'h2, d)
    ctrl_u.rst(2);
    ctrl_u.cyc(4);
    rd(REG_STATUS);
    `CHK("status wait", 8'h02, d[7:0])
    `CHK("odt held", 1'h0, odt_en_out)
    ctrl_u.init(1'h0);
    for (int i = 0; i < 60 && ready_out !== 1'h1; i++) @(posedge clk_in);
    rd(REG_STATUS);
    `CHK("status done", 17'h19e60, {ready_out, d[15:0]})
    for (int i = 0; i < 4; i++) begin
      rd(REG_MR0 + 32'(4 * i));
      `CHK("mode reg", {17'h0, mrv[i]}, d)
    end
    ctrl_u.cmd(CMD_ACT, 3'h5, 15'h1234);
    burst(3'h5, 15'h0401, 4);
    rd(REG_ACCESS);
    `CHK("access", 32'h0006_8401, d)
    rd(32'h0000_0040);
    `CHK("unmapped", RESP_SLVERR, rr)
    ctrl_u.term(1'h1);
    ctrl_u.cyc(4);
    `CHK("odt on", 1'h1, odt_en_out)
    ctrl_u.cmd(CMD_ACT, 3'h2, 15'h0055);
    ctrl_u.cmd(CMD_MRS, BA_MR0, 15'h0109);
    rd(REG_MR0);
    `CHK("mode rewrite", 32'h0000_0109, d)
    ev = '{3'h5, 3'h7, 3'h0, 3'h0};
    od = '{3'h4, 3'h6, 3'h0, 3'h0};
    burst(3'h2, 15'h0005, 2);
    ctrl_u.rst(2);
    ctrl_u.cyc(4);
    ctrl_u.init(1'h1);
    rd(REG_STATUS);
    `CHK("bad order", 6'h17, {ready_out, d[12:8]})
    wr(REG_CONTROL, 32'h3, 4'hf);
    rd(REG_STATUS);
    `CHK("err clear", 1'h0, d[8])
    complete_run();
  end
endmodule : testbench
